// [inc/crma_pkg.sv]
package crma_pkg;

  // ------------------------------------------------------------
  // message tokens
  // ------------------------------------------------------------
  localparam logic [7:0] TOK_WRITE = 8'hC0;
  localparam logic [7:0] TOK_READ  = 8'hC1;
  localparam logic [7:0] TOK_END   = 8'h01;
  localparam logic [7:0] TOK_ACK   = 8'h03;
  localparam logic [7:0] TOK_NAK   = 8'h04;

  // ------------------------------------------------------------
  // addressing
  // ------------------------------------------------------------
  localparam logic [7:0]  NOREPLY_LOW = 8'hFF;
  localparam logic [15:0] TILE_SUFFIX = 16'hC20C;
  localparam logic [15:0] NODE_SUFFIX = 16'hC30C;
  localparam logic [7:0]  PS_RES_TYPE = 8'h0C;
  localparam int          PS_SHIFT    = 8;

  localparam logic [1:0] BANK_PS   = 2'h0;
  localparam logic [1:0] BANK_TILE = 2'h1;
  localparam logic [1:0] BANK_NODE = 2'h2;

  // ------------------------------------------------------------
  // field lengths in bytes, minus one, and reset values
  // ------------------------------------------------------------
  localparam logic [1:0]  RET_LAST  = 2'h2;
  localparam logic [1:0]  REG_LAST  = 2'h1;
  localparam logic [1:0]  DATA_LAST = 2'h3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef struct packed {
    logic       ctrl;
    logic [7:0] value;
  } crma_token_s;

  typedef struct packed {
    logic [31:0] dest;
    crma_token_s tok;
  } crma_rx_s;

endpackage

// [logic/crma_regfile.sv]
`timescale 1ns/1ps
module crma_regfile
  import crma_pkg::*;
#(
  parameter int AW = 6
) (
  input  wire logic          core_clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          en_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [31:0]   wdata_i,
  output logic      [31:0]   rdata_o
);

  logic [31:0] mem_reg [2**AW];

  // read data is registered and holds until the next access
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_reg[i] <= REG_RESET;
      end
      rdata_o <= REG_RESET;
    end else if (en_i) begin
      if (we_i) begin
        mem_reg[addr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[addr_i];
    end
  end

endmodule

// [logic/crma_engine.sv]
`timescale 1ns/1ps
// Overview of operation
// - write with low byte all ones: silent
// - multi-byte fields travel most significant byte first
// - tile service: tile id plus fixed suffix
// - node service: node id plus fixed suffix
// - write: 192, return, register, data, 1
// - read: 193, return, register, 1
// - write reply: 3,1 success; 4,1 failure
// - read reply: 3,data,1 success; 4,1 failure
// - status instructions move one full word
module crma_engine
  import crma_pkg::*;
#(
  parameter int              IW    = 4,
  parameter logic [4*16-1:0] WPROT = 64'h0000_0000_0000_0000
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] tile_id_i,
  input  wire logic [15:0] node_id_i,
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  input  wire crma_rx_s    rx_i,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output crma_token_s      tx_tok_o,
  output logic      [23:0] tx_dest_o,
  input  wire logic        ps_valid_i,
  input  wire logic        ps_write_i,
  input  wire logic [31:0] ps_resid_i,
  input  wire logic [31:0] ps_wdata_i,
  output logic             ps_done_o,
  output logic             ps_error_o,
  output logic      [31:0] ps_rdata_o
);

  typedef enum {
    ST_IDLE, ST_RET, ST_REGN, ST_DATA, ST_END, ST_EXEC,
    ST_WAIT, ST_HEAD, ST_BYTES, ST_TAIL, ST_PSWAIT
  } crma_state_e;

  crma_state_e state_reg, state_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic [23:0] ret_reg, ret_next;
  logic [15:0] regn_reg, regn_next;
  logic [31:0] data_reg, data_next;
  logic [1:0]  bank_reg, bank_next;
  logic        wr_reg, wr_next;
  logic        ok_reg, ok_next;
  crma_token_s tok_reg, tok_next;
  logic        done_reg, done_next;
  logic        err_reg, err_next;
  logic [31:0] psr_reg, psr_next;

  logic [IW+1:0] mem_addr;
  logic          mem_en;
  logic          mem_we;
  logic [31:0]   mem_wdata;
  logic [31:0]   mem_rdata;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire rx_fire   = rx_valid_i && rx_ready_o;
  wire tx_fire   = tx_valid_o && tx_ready_i;
  wire is_ctrl   = rx_i.tok.ctrl;
  wire [7:0] val = rx_i.tok.value;
  wire to_tile   = rx_i.dest == {tile_id_i, TILE_SUFFIX};
  wire to_node   = rx_i.dest == {node_id_i, NODE_SUFFIX};
  wire hdr_ok    = is_ctrl && (val == TOK_WRITE || val == TOK_READ) && (to_tile || to_node);
  wire noreply   = ret_reg[7:0] == NOREPLY_LOW;

  wire [IW+1:0] req_addr = {bank_reg, regn_reg[IW-1:0]};
  wire req_exist = regn_reg[15:IW] == '0;
  wire req_ok    = req_exist && !(wr_reg && WPROT[req_addr]);

  // resource id = (reg << 8) | 0C
  wire [23:0]   ps_regn  = ps_resid_i[31:PS_SHIFT];
  wire [IW+1:0] ps_addr  = {BANK_PS, ps_regn[IW-1:0]};
  wire ps_take  = ps_valid_i && !done_reg && state_reg == ST_IDLE;
  wire ps_ok    = ps_resid_i[7:0] == PS_RES_TYPE && ps_regn[23:IW] == '0
                  && !(ps_write_i && WPROT[ps_addr]);

  wire exec_go  = state_reg == ST_EXEC && req_ok;
  wire ps_go    = ps_take && ps_ok;

  assign mem_en     = exec_go || ps_go;
  assign mem_we     = (exec_go && wr_reg) || (ps_go && ps_write_i);
  assign mem_addr   = ps_go ? ps_addr : req_addr;
  assign mem_wdata  = ps_go ? ps_wdata_i : data_reg;

  assign rx_ready_o = (state_reg == ST_IDLE && !ps_take) || state_reg == ST_RET
                      || state_reg == ST_REGN || state_reg == ST_DATA || state_reg == ST_END;
  assign tx_valid_o = state_reg == ST_HEAD || state_reg == ST_BYTES || state_reg == ST_TAIL;
  assign tx_tok_o   = tok_reg;
  assign tx_dest_o  = ret_reg;
  assign ps_done_o  = done_reg;
  assign ps_error_o = err_reg;
  assign ps_rdata_o = psr_reg;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    ret_next   = ret_reg;
    regn_next  = regn_reg;
    data_next  = data_reg;
    bank_next  = bank_reg;
    wr_next    = wr_reg;
    ok_next    = ok_reg;
    tok_next   = tok_reg;
    done_next  = 1'b0;
    err_next   = err_reg;
    psr_next   = psr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ps_take) begin
          err_next = !ps_ok;
          if (ps_ok && !ps_write_i) begin
            state_next = ST_PSWAIT;
          end else begin
            done_next = 1'b1;
          end
        end else if (rx_fire && hdr_ok) begin
          // anything else arriving here is stray traffic and is dropped
          wr_next    = val == TOK_WRITE;
          bank_next  = to_tile ? BANK_TILE : BANK_NODE;
          cnt_next   = '0;
          state_next = ST_RET;
        end
      end
      ST_RET: begin
        if (rx_fire) begin
          ret_next = {ret_reg[15:0], val};
          cnt_next = cnt_reg + 2'd1;
          if (is_ctrl) begin
            state_next = ST_IDLE;
          end else if (cnt_reg == RET_LAST) begin
            cnt_next   = '0;
            state_next = ST_REGN;
          end
        end
      end
      ST_REGN: begin
        if (rx_fire) begin
          regn_next = {regn_reg[7:0], val};
          cnt_next  = cnt_reg + 2'd1;
          if (is_ctrl) begin
            state_next = ST_IDLE;
          end else if (cnt_reg == REG_LAST) begin
            cnt_next   = '0;
            state_next = wr_reg ? ST_DATA : ST_END;
          end
        end
      end
      ST_DATA: begin
        if (rx_fire) begin
          data_next = {data_reg[23:0], val};
          cnt_next  = cnt_reg + 2'd1;
          if (is_ctrl) begin
            state_next = ST_IDLE;
          end else if (cnt_reg == DATA_LAST) begin
            state_next = ST_END;
          end
        end
      end
      ST_END: begin
        if (rx_fire) begin
          // a malformed closing token aborts without touching registers
          state_next = (is_ctrl && val == TOK_END) ? ST_EXEC : ST_IDLE;
        end
      end
      ST_EXEC: begin
        ok_next  = req_ok;
        tok_next = '{ctrl: 1'b1, value: req_ok ? TOK_ACK : TOK_NAK};
        if (req_ok && !wr_reg) begin
          state_next = ST_WAIT;
        end else if (wr_reg && noreply) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_HEAD;
        end
      end
      ST_WAIT: begin
        data_next  = mem_rdata;
        state_next = ST_HEAD;
      end
      ST_HEAD: begin
        if (tx_fire) begin
          cnt_next = '0;
          if (ok_reg && !wr_reg) begin
            tok_next   = '{ctrl: 1'b0, value: data_reg[31:24]};
            data_next  = {data_reg[23:0], 8'h00};
            state_next = ST_BYTES;
          end else begin
            tok_next   = '{ctrl: 1'b1, value: TOK_END};
            state_next = ST_TAIL;
          end
        end
      end
      ST_BYTES: begin
        if (tx_fire) begin
          cnt_next = cnt_reg + 2'd1;
          if (cnt_reg == DATA_LAST) begin
            tok_next   = '{ctrl: 1'b1, value: TOK_END};
            state_next = ST_TAIL;
          end else begin
            tok_next  = '{ctrl: 1'b0, value: data_reg[31:24]};
            data_next = {data_reg[23:0], 8'h00};
          end
        end
      end
      ST_TAIL: begin
        if (tx_fire) begin
          state_next = ST_IDLE;
        end
      end
      ST_PSWAIT: begin
        psr_next   = mem_rdata;
        done_next  = 1'b1;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      ret_reg   <= '0;
      regn_reg  <= '0;
      data_reg  <= '0;
      bank_reg  <= BANK_PS;
      wr_reg    <= 1'b0;
      ok_reg    <= 1'b0;
      tok_reg   <= '0;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      psr_reg   <= REG_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      ret_reg   <= ret_next;
      regn_reg  <= regn_next;
      data_reg  <= data_next;
      bank_reg  <= bank_next;
      wr_reg    <= wr_next;
      ok_reg    <= ok_next;
      tok_reg   <= tok_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
      psr_reg   <= psr_next;
    end
  end

  // ------------------------------------------------------------
  // register storage, three banks
  // ------------------------------------------------------------
  crma_regfile #(
    .AW (IW + 2)
  ) u_regs (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .en_i       (mem_en),
    .we_i       (mem_we),
    .addr_i     (mem_addr),
    .wdata_i    (mem_wdata),
    .rdata_o    (mem_rdata)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  ret_length_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_RET && rx_fire && !is_ctrl && cnt_reg == RET_LAST) |=> state_reg == ST_REGN)
    else $error("return address not three bytes");
  silent_write_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_EXEC && wr_reg && noreply) |=> !tx_valid_o [*2])
    else $error("reply sent for silent write");
  read_msb_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_HEAD && tx_fire && ok_reg && !wr_reg)
    |=> tx_tok_o.value == mem_rdata[31:24] && !tx_tok_o.ctrl)
    else $error("read data not msb first");
  ps_decode_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (ps_take && ps_resid_i[7:0] != PS_RES_TYPE) |=> ps_done_o && ps_error_o)
    else $error("bad status resource accepted");
  dest_filter_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_IDLE && rx_fire && !to_tile && !to_node) |=> state_reg == ST_IDLE)
    else $error("foreign destination accepted");
  req_close_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_END && rx_fire && is_ctrl && val == TOK_END) |=> state_reg == ST_EXEC)
    else $error("closed request not executed");
  head_token_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_HEAD) |-> tx_tok_o.ctrl && tx_tok_o.value == (ok_reg ? TOK_ACK : TOK_NAK))
    else $error("wrong reply head token");
  fail_tail_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_HEAD && tx_fire && !ok_reg)
    |=> tx_valid_o && tx_tok_o.ctrl && tx_tok_o.value == TOK_END)
    else $error("failure reply not closed");
  ps_word_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_PSWAIT) |=> ps_done_o && ps_rdata_o == $past(mem_rdata))
    else $error("status word not returned");
  fail_nowrite_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (state_reg == ST_EXEC && !req_ok)
    |-> !mem_en ##1 state_reg == ((wr_reg && noreply) ? ST_IDLE : ST_HEAD))
    else $error("failed request touched registers");

endmodule

// [verification/crma_chanend_model.sv]
`timescale 1ns/1ps
module crma_chanend_model
  import crma_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        slow_i,
  output logic             rx_valid_o,
  input  wire logic        rx_ready_i,
  output crma_rx_s         rx_o,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire crma_token_s tx_tok_i,
  input  wire logic [23:0] tx_dest_i
);
  crma_token_s got_q[$];
  logic [23:0] dest_q[$];
  logic        tog_reg = 1'b0;

  initial begin
    rx_valid_o = 1'b0;
    rx_o       = '0;
  end

  // slow sink stalls every other cycle
  assign tx_ready_o = !slow_i || tog_reg;

  always @(posedge core_clk_i) begin
    tog_reg <= !tog_reg;
    if (tx_valid_i && tx_ready_o) begin
      got_q.push_back(tx_tok_i);
      dest_q.push_back(tx_dest_i);
    end
  end

  task automatic send_tok(input logic [31:0] dst, input logic c, input logic [7:0] v);
    @(posedge core_clk_i);
    rx_valid_o <= 1'b1;
    rx_o       <= '{dest: dst, tok: '{ctrl: c, value: v}};
    @(negedge core_clk_i);
    while (!rx_ready_i) @(negedge core_clk_i);
    @(posedge core_clk_i);
    rx_valid_o <= 1'b0;
    // released lines must not keep the last value
    rx_o       <= ~rx_o;
  endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import crma_pkg::*;
;
  localparam logic [63:0] WPROT_TB = 64'h0000_0000_0020_0000;
  localparam logic [31:0] TILE_D   = {16'h0A01, TILE_SUFFIX};
  localparam logic [31:0] NODE_D   = {16'h0B02, NODE_SUFFIX};

  logic        core_clk, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, slow;
  logic        ps_valid, ps_write, ps_done, ps_error;
  crma_rx_s    rx;
  crma_token_s tx_tok;
  logic [23:0] tx_dest;
  logic [31:0] ps_resid, ps_wdata, ps_rdata;
  int          fail_count = 0;
  int          total_checks = 0;
  crma_token_s exp_q[$];

  crma_engine #(.IW(4), .WPROT(WPROT_TB)) dut_u (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .tile_id_i(16'h0A01), .node_id_i(16'h0B02),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_i(rx), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .tx_tok_o(tx_tok), .tx_dest_o(tx_dest), .ps_valid_i(ps_valid),
    .ps_write_i(ps_write), .ps_resid_i(ps_resid), .ps_wdata_i(ps_wdata),
    .ps_done_o(ps_done), .ps_error_o(ps_error), .ps_rdata_o(ps_rdata));

  crma_chanend_model chan_u (
    .core_clk_i(core_clk), .slow_i(slow), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_o(rx), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_tok_i(tx_tok),
    .tx_dest_i(tx_dest));

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  function automatic crma_token_s tk(input logic c, input logic [7:0] v);
    return '{ctrl: c, value: v};
  endfunction

  task automatic chk_tok(input crma_token_s got, input crma_token_s exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic exp_nak;
    exp_q = '{tk(1'b1, TOK_NAK), tk(1'b1, TOK_END)};
  endtask

  task automatic exp_data(input logic [31:0] d);
    exp_q = '{tk(1'b1, TOK_ACK), tk(1'b0, d[31:24]), tk(1'b0, d[23:16]),
              tk(1'b0, d[15:8]), tk(1'b0, d[7:0]), tk(1'b1, TOK_END)};
  endtask

  // extra settle time also catches a reply that should never come
  task automatic reply(input logic [23:0] ret);
    int n;
    for (n = 0; n < 200 && chan_u.got_q.size() < exp_q.size(); n++) @(negedge core_clk);
    repeat (10) @(negedge core_clk);
    chk_word(32'(chan_u.got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[k]) begin
      if (k < chan_u.got_q.size()) begin
        chk_tok(chan_u.got_q[k], exp_q[k]);
        chk_word({8'h00, chan_u.dest_q[k]}, {8'h00, ret});
      end
    end
    exp_q.delete();
  endtask

  task automatic req(input logic [31:0] dst, input logic wr, input logic [23:0] ret,
                     input logic [15:0] rg, input logic [31:0] d);
    chan_u.got_q.delete();
    chan_u.dest_q.delete();
    chan_u.send_tok(dst, 1'b1, wr ? TOK_WRITE : TOK_READ);
    for (int i = 2; i >= 0; i--) chan_u.send_tok(dst, 1'b0, ret[i*8 +: 8]);
    for (int i = 1; i >= 0; i--) chan_u.send_tok(dst, 1'b0, rg[i*8 +: 8]);
    if (wr) for (int i = 3; i >= 0; i--) chan_u.send_tok(dst, 1'b0, d[i*8 +: 8]);
    chan_u.send_tok(dst, 1'b1, TOK_END);
    reply(ret);
  endtask

  task automatic ps_op(input logic wr, input logic [7:0] rg, input logic [7:0] typ,
                       input logic [31:0] wd, output logic e, output logic [31:0] r);
    int n;
    @(posedge core_clk);
    ps_valid <= 1'b1;
    ps_write <= wr;
    ps_resid <= (32'(rg) << PS_SHIFT) | {24'h0, typ};
    ps_wdata <= wd;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (ps_done !== 1'b1 && n < 50);
    chk_word({31'h0, ps_done}, 32'h1);
    e = ps_error;
    r = ps_rdata;
    @(posedge core_clk);
    ps_valid <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_tile;
    exp_q = '{tk(1'b1, TOK_ACK), tk(1'b1, TOK_END)};
    req(TILE_D, 1'b1, 24'h123456, 16'h0003, 32'hA1B2C3D4);
    @(posedge core_clk);
    slow <= 1'b1;
    exp_data(32'hA1B2C3D4);
    req(TILE_D, 1'b0, 24'h654321, 16'h0003, 32'h0);
    @(posedge core_clk);
    slow <= 1'b0;
  endtask

  task automatic sc_node;
    req(NODE_D, 1'b1, 24'h0042FF, 16'h0007, 32'h0F1E2D3C);
    exp_data(32'h0F1E2D3C);
    req(NODE_D, 1'b0, 24'h0042FF, 16'h0007, 32'h0);
    exp_data(32'h0);
    req(TILE_D, 1'b0, 24'h000100, 16'h0007, 32'h0);
  endtask

  task automatic sc_refuse;
    exp_nak();
    req(TILE_D, 1'b1, 24'h000200, 16'h0010, 32'h11111111);
    exp_nak();
    req(TILE_D, 1'b1, 24'h000200, 16'h0005, 32'h22222222);
    // refused silent write: no reply and no change
    req(TILE_D, 1'b1, 24'h0002FF, 16'h0005, 32'h33333333);
    exp_data(32'h0);
    req(TILE_D, 1'b0, 24'h000200, 16'h0005, 32'h0);
    exp_nak();
    req(TILE_D, 1'b0, 24'h000200, 16'h0010, 32'h0);
  endtask

  task automatic sc_drop;
    req({16'h0A02, TILE_SUFFIX}, 1'b1, 24'h000300, 16'h0003, 32'h0);
    chan_u.send_tok(TILE_D, 1'b1, TOK_WRITE);
    chan_u.send_tok(TILE_D, 1'b0, 8'h00);
    chan_u.send_tok(TILE_D, 1'b1, TOK_END);
    reply(24'h0);
    exp_data(32'hA1B2C3D4);
    req(TILE_D, 1'b0, 24'h000400, 16'h0003, 32'h0);
  endtask

  task automatic sc_status;
    logic        e;
    logic [31:0] r;
    ps_op(1'b1, 8'h03, PS_RES_TYPE, 32'hDEADBEEF, e, r);
    chk_word({31'h0, e}, 32'h0);
    ps_op(1'b0, 8'h03, PS_RES_TYPE, 32'h0, e, r);
    chk_word(r, 32'hDEADBEEF);
    ps_op(1'b0, 8'h03, 8'h0D, 32'h0, e, r);
    chk_word({31'h0, e}, 32'h1);
    ps_op(1'b1, 8'h10, PS_RES_TYPE, 32'h5, e, r);
    chk_word({31'h0, e}, 32'h1);
    ps_op(1'b1, 8'h03, 8'h0D, 32'h5, e, r);
    chk_word({31'h0, e}, 32'h1);
    ps_op(1'b0, 8'h03, PS_RES_TYPE, 32'h0, e, r);
    chk_word(r, 32'hDEADBEEF);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    reset_n  = 1'b0;
    slow     = 1'b0;
    ps_valid = 1'b0;
    ps_write = 1'b0;
    ps_resid = 32'h0;
    ps_wdata = 32'h0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    sc_tile();
    sc_node();
    sc_refuse();
    sc_drop();
    sc_status();
    tally_and_finish();
  end
endmodule
